//--- rtl/sensor_cmd_defines.vh
`ifndef SENSOR_CMD_DEFINES_VH
`define SENSOR_CMD_DEFINES_VH

// register byte offsets on the apb bus
`define OFS_FIRST_WORD 8'h00
`define OFS_SECOND_WORD 8'h04
`define OFS_TRIM_CONFIG 8'h08
`define OFS_AVG_CONFIG 8'h0C
`define OFS_STATUS 8'h10
`define OFS_OSC_RATIO 8'h14

// reset values
`define RST_TRIM_CONFIG 16'h0012
`define RST_AVG_CONFIG 16'h0800

// field positions
`define TRIM_FIELD_HI 4
`define TRIM_FIELD_LO 0
`define AVG_EXP_HI 2
`define AVG_EXP_LO 0

// command opcodes
`define CMD_ENTER 8'h72
`define CMD_ENTER_ARG 8'hD1
`define CMD_UNLOCK 8'h6C
`define CMD_UNLOCK_ARG1 8'hF7
`define CMD_UNLOCK_ARG2 8'h42
`define CMD_NVM_TO_RAM 8'hC0
`define CMD_RAM_TO_NVM 8'hC3
`define CMD_NVM_WORD 8'hAD
`define CMD_NVM_SIGN 8'hC9
`define CMD_COUNTED 8'h62
`define CMD_OSC_RATIO 8'h50
`define CMD_OSC_TRIM 8'h65
`define CMD_READ_TRIM 8'h1D
`define CMD_CYCLIC_FIRST 8'h01
`define CMD_CYCLIC_LAST 8'h08

// response codes, high byte or whole word, and the checksum base
`define RESP_OK_HI 8'hC3
`define RESP_FAIL_HI 8'hCF
`define RESP_DIAG_HI 8'hC0
`define RESP_BAD_CMD 16'hCF00
`define RESP_PROC_ERR 16'hC000
`define CKSUM_BASE 8'hFF

// nvm operation codes
`define NVM_OP_TO_RAM 2'b00
`define NVM_OP_TO_NVM 2'b01
`define NVM_OP_WORD 2'b10
`define NVM_OP_SIGN 2'b11

// timing
`define CLK_HZ 20000000
`define NVM_TIMEOUT_MS 300
`define NVM_TIMEOUT_CYC ((`CLK_HZ / 1000) * `NVM_TIMEOUT_MS)

`endif

//--- rtl/osc_ratio_meter.v
`timescale 1ns/1ps
module osc_ratio_meter (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // link clock pin
    input wire owi_clk_pin,
    // measurement handshake
    input wire start,
    output reg done,
    output reg [15:0] ratio
);
    reg sync1;
    reg sync2;
    reg sync3;
    reg filt;
    reg armed;
    reg counting;
    reg [15:0] count;
    wire rise;

    // a change counts only once the last two stages agree
    assign rise = sync2 & sync3 & ~filt;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            filt <= 1'b0;
            armed <= 1'b0;
            counting <= 1'b0;
            count <= 16'h0000;
            done <= 1'b0;
            ratio <= 16'h0000;
        end else begin
            sync1 <= owi_clk_pin;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                filt <= sync3;
            end
            done <= 1'b0;
            if (start) begin
                armed <= 1'b1;
                counting <= 1'b0;
                count <= 16'h0000;
            end else if (armed && rise) begin
                // one full link period, rising edge to rising edge
                if (counting) begin
                    ratio <= count;
                    done <= 1'b1;
                    armed <= 1'b0;
                    counting <= 1'b0;
                end else begin
                    counting <= 1'b1;
                    count <= 16'h0001;
                end
            end else if (counting && count != 16'hFFFF) begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule

//--- rtl/sensor_command_processor.v
`timescale 1ns/1ps
`include "sensor_cmd_defines.vh"

module sensor_command_processor #(
    parameter NVM_TIMEOUT = `NVM_TIMEOUT_CYC
) (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // command bytes from the serial front end
    input wire cmd_valid,
    input wire [7:0] cmd_byte,
    input wire cmd_end,
    input wire cmd_one_wire,
    input wire cmd_primary,
    input wire secondary_fault,
    // one-wire link clock pin
    input wire owi_clk_pin,
    // converter
    output wire conv_run,
    output reg conv_temp_sel,
    input wire conv_done,
    input wire conv_is_temp,
    input wire [15:0] conv_data,
    input wire [7:0] conv_diag,
    input wire conv_diag_temporary,
    // nonvolatile memory
    output reg charge_pump_en,
    output reg nvm_req,
    output reg [1:0] nvm_op,
    output reg [15:0] nvm_word,
    input wire nvm_done,
    input wire nvm_fail,
    input wire pump_fault,
    // status
    output wire [4:0] osc_trim,
    output wire command_session,
    output wire busy,
    output reg secondary_addr_en
);
    localparam [4:0] S_NORMAL = 5'b00001;
    localparam [4:0] S_IDLE = 5'b00010;
    localparam [4:0] S_COUNT = 5'b00100;
    localparam [4:0] S_NVM = 5'b01000;
    localparam [4:0] S_OSC = 5'b10000;

    reg [4:0] state;
    reg [15:0] first_word;
    reg [15:0] second_word;
    reg [15:0] trim_config_word;
    reg [15:0] avg_config_word;
    reg [7:0] byte0;
    reg [7:0] byte1;
    reg [7:0] byte2;
    reg [1:0] nbytes;
    reg frame_lost;
    reg halted;
    reg first_sample;
    reg [15:0] cycles_left;
    reg [15:0] bridge_avg;
    reg [15:0] temp_avg;
    reg [22:0] wait_count;
    reg [7:0] cur_cmd;
    reg meter_start;
    wire meter_done;
    wire [15:0] osc_ratio;
    wire [2:0] average_exponent;
    wire [15:0] data_word;
    wire apb_write;
    wire take_cmd;

    assign pready = 1'b1;
    assign apb_write = psel & penable & pwrite;
    assign average_exponent = avg_config_word[`AVG_EXP_HI:`AVG_EXP_LO];
    assign osc_trim = trim_config_word[`TRIM_FIELD_HI:`TRIM_FIELD_LO];
    assign command_session = ~state[0];
    assign busy = state[2] | state[3] | state[4];
    assign data_word = {byte1, byte2};
    assign conv_run = (state[0] & ~halted) | state[2];
    assign take_cmd = cmd_end & ~frame_lost & (nbytes != 2'b00) & ~busy;

    // checksum over both bytes of a data word
    function [7:0] cksum;
        input [15:0] w;
        begin
            cksum = `CKSUM_BASE - (w[15:8] + w[7:0]);
        end
    endfunction

    // output filter with the differential coefficient held at zero
    function [15:0] filt_step;
        input [15:0] acc;
        input [15:0] x;
        input [2:0] sh;
        reg signed [16:0] diff;
        begin
            diff = $signed({1'b0, x}) - $signed({1'b0, acc});
            diff = diff >>> sh;
            filt_step = acc + diff[15:0];
        end
    endfunction

    osc_ratio_meter u_meter (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .owi_clk_pin(owi_clk_pin),
        .start(meter_start),
        .done(meter_done),
        .ratio(osc_ratio)
    );

    // apb read data is captured in the setup cycle so the access cycle answers at once
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
                `OFS_FIRST_WORD: prdata <= {16'h0000, first_word};
                `OFS_SECOND_WORD: prdata <= {16'h0000, second_word};
                `OFS_TRIM_CONFIG: prdata <= {16'h0000, trim_config_word};
                `OFS_AVG_CONFIG: prdata <= {16'h0000, avg_config_word};
                `OFS_STATUS: prdata <= {23'h000000, secondary_addr_en, charge_pump_en,
                    halted, state, nvm_req};
                `OFS_OSC_RATIO: prdata <= {16'h0000, osc_ratio};
                default: begin
                    prdata <= 32'h00000000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // command byte collection
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte0 <= 8'h00;
            byte1 <= 8'h00;
            byte2 <= 8'h00;
            nbytes <= 2'b00;
            frame_lost <= 1'b0;
        end else if (cmd_end) begin
            nbytes <= 2'b00;
            frame_lost <= 1'b0;
        end else if (cmd_valid) begin
            if (busy) begin
                frame_lost <= 1'b1;
            end else begin
                case (nbytes)
                    2'b00: byte0 <= cmd_byte;
                    2'b01: byte1 <= cmd_byte;
                    2'b10: byte2 <= cmd_byte;
                    default: byte2 <= byte2;
                endcase
                if (nbytes != 2'b11) begin
                    nbytes <= nbytes + 2'b01;
                end
            end
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_NORMAL;
            first_word <= 16'h0000;
            second_word <= 16'h0000;
            trim_config_word <= `RST_TRIM_CONFIG;
            avg_config_word <= `RST_AVG_CONFIG;
            halted <= 1'b0;
            first_sample <= 1'b0;
            cycles_left <= 16'h0000;
            bridge_avg <= 16'h0000;
            temp_avg <= 16'h0000;
            wait_count <= 23'h000000;
            cur_cmd <= 8'h00;
            meter_start <= 1'b0;
            conv_temp_sel <= 1'b0;
            charge_pump_en <= 1'b0;
            nvm_req <= 1'b0;
            nvm_op <= `NVM_OP_TO_RAM;
            nvm_word <= 16'h0000;
            secondary_addr_en <= 1'b1;
        end else begin
            meter_start <= 1'b0;
            if (apb_write && paddr == `OFS_TRIM_CONFIG) begin
                trim_config_word <= pwdata[15:0];
            end
            if (apb_write && paddr == `OFS_AVG_CONFIG) begin
                avg_config_word <= pwdata[15:0];
            end
            if (secondary_fault) begin
                secondary_addr_en <= 1'b0;
            end
            case (state)
                S_NORMAL: begin
                    // entry wins over a result landing in the same cycle
                    if (take_cmd && !cmd_one_wire && nbytes == 2'b10 &&
                        byte0 == `CMD_ENTER && byte1 == `CMD_ENTER_ARG) begin
                        state <= S_IDLE;
                        halted <= 1'b0;
                        first_word <= {`RESP_OK_HI, `CMD_ENTER};
                        second_word <= {cksum({`RESP_OK_HI, `CMD_ENTER}), `CMD_ENTER};
                        if (cmd_primary) begin
                            secondary_addr_en <= 1'b1;
                        end
                    end else if (conv_done && !conv_is_temp && !halted) begin
                        if (conv_diag != 8'h00) begin
                            first_word <= {`RESP_DIAG_HI, conv_diag};
                            second_word <= {cksum({`RESP_DIAG_HI, conv_diag}), 8'h00};
                            halted <= ~conv_diag_temporary;
                        end else begin
                            first_word <= conv_data;
                            second_word <= {cksum(conv_data), 8'h00};
                        end
                    end
                end
                S_IDLE: begin
                    if (take_cmd) begin
                        cur_cmd <= byte0;
                        // default answer unless a branch below overrides it
                        first_word <= `RESP_BAD_CMD;
                        second_word <= {cksum(`RESP_BAD_CMD), byte0};
                        if (byte0 == `CMD_ENTER && nbytes == 2'b10 &&
                            byte1 == `CMD_ENTER_ARG) begin
                            first_word <= {`RESP_OK_HI, `CMD_ENTER};
                            second_word <= {cksum({`RESP_OK_HI, `CMD_ENTER}), `CMD_ENTER};
                            if (cmd_primary) begin
                                secondary_addr_en <= 1'b1;
                            end
                        end else if (byte0 == `CMD_UNLOCK && nbytes == 2'b11 &&
                            byte1 == `CMD_UNLOCK_ARG1 && byte2 == `CMD_UNLOCK_ARG2) begin
                            if (pump_fault) begin
                                first_word <= {`RESP_FAIL_HI, `CMD_UNLOCK};
                                second_word <= {cksum({`RESP_FAIL_HI, `CMD_UNLOCK}),
                                    `CMD_UNLOCK};
                            end else begin
                                charge_pump_en <= 1'b1;
                                first_word <= {`RESP_OK_HI, `CMD_UNLOCK};
                                second_word <= {cksum({`RESP_OK_HI, `CMD_UNLOCK}),
                                    `CMD_UNLOCK};
                            end
                        end else if ((byte0 == `CMD_NVM_TO_RAM || byte0 == `CMD_RAM_TO_NVM ||
                            byte0 == `CMD_NVM_SIGN) && nbytes == 2'b01) begin
                            state <= S_NVM;
                            nvm_req <= 1'b1;
                            wait_count <= 23'h000000;
                            nvm_word <= 16'h0000;
                            nvm_op <= (byte0 == `CMD_NVM_TO_RAM) ? `NVM_OP_TO_RAM :
                                (byte0 == `CMD_RAM_TO_NVM) ? `NVM_OP_TO_NVM : `NVM_OP_SIGN;
                        end else if (byte0 == `CMD_NVM_WORD && nbytes == 2'b11) begin
                            state <= S_NVM;
                            nvm_req <= 1'b1;
                            wait_count <= 23'h000000;
                            nvm_word <= data_word;
                            nvm_op <= `NVM_OP_WORD;
                        end else if (byte0 == `CMD_READ_TRIM && nbytes == 2'b01) begin
                            first_word <= trim_config_word;
                            second_word <= {cksum(trim_config_word), `CMD_READ_TRIM};
                        end else if (byte0 == `CMD_OSC_TRIM && nbytes == 2'b11) begin
                            // only the trim field changes, and takes effect at once
                            trim_config_word <= {trim_config_word[15:5], byte2[4:0]};
                            first_word <= {trim_config_word[15:5], byte2[4:0]};
                            second_word <= {cksum({trim_config_word[15:5], byte2[4:0]}),
                                `CMD_OSC_TRIM};
                        end else if (byte0 == `CMD_OSC_RATIO && nbytes == 2'b01 &&
                            cmd_one_wire) begin
                            state <= S_OSC;
                            meter_start <= 1'b1;
                            wait_count <= 23'h000000;
                        end else if (byte0 == `CMD_COUNTED && nbytes == 2'b11) begin
                            cycles_left <= data_word;
                            first_sample <= 1'b1;
                            conv_temp_sel <= 1'b1;
                            if (data_word != 16'h0000) begin
                                state <= S_COUNT;
                            end else begin
                                first_word <= bridge_avg;
                                second_word <= temp_avg;
                            end
                        end else if (byte0 >= `CMD_CYCLIC_FIRST && byte0 <= `CMD_CYCLIC_LAST &&
                            nbytes == 2'b01) begin
                            // back to normal measuring; the first result or diagnostic
                            // code refreshes the words
                            state <= S_NORMAL;
                            halted <= 1'b0;
                            charge_pump_en <= 1'b0;
                            first_word <= first_word;
                            second_word <= second_word;
                        end
                    end
                end
                S_COUNT: begin
                    if (conv_done && conv_temp_sel && conv_is_temp) begin
                        temp_avg <= first_sample ? conv_data :
                            filt_step(temp_avg, conv_data, average_exponent);
                        second_word <= first_sample ? conv_data :
                            filt_step(temp_avg, conv_data, average_exponent);
                        conv_temp_sel <= 1'b0;
                    end else if (conv_done && !conv_temp_sel && !conv_is_temp) begin
                        bridge_avg <= first_sample ? conv_data :
                            filt_step(bridge_avg, conv_data, average_exponent);
                        first_word <= first_sample ? conv_data :
                            filt_step(bridge_avg, conv_data, average_exponent);
                        first_sample <= 1'b0;
                        conv_temp_sel <= (cycles_left != 16'h0001);
                        cycles_left <= cycles_left - 16'h0001;
                        if (cycles_left == 16'h0001) begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_NVM: begin
                    wait_count <= wait_count + 23'h000001;
                    if (nvm_done) begin
                        nvm_req <= 1'b0;
                        state <= S_IDLE;
                        if (!nvm_fail) begin
                            first_word <= {`RESP_OK_HI, cur_cmd};
                            second_word <= {cksum({`RESP_OK_HI, cur_cmd}), cur_cmd};
                        end else if (cur_cmd == `CMD_RAM_TO_NVM) begin
                            first_word <= {`RESP_FAIL_HI, cur_cmd};
                            second_word <= {cksum({`RESP_FAIL_HI, cur_cmd}), cur_cmd};
                        end else begin
                            first_word <= `RESP_PROC_ERR;
                            second_word <= {cksum(`RESP_PROC_ERR), cur_cmd};
                        end
                    end else if (wait_count >= NVM_TIMEOUT - 1) begin
                        nvm_req <= 1'b0;
                        state <= S_IDLE;
                        first_word <= `RESP_PROC_ERR;
                        second_word <= {cksum(`RESP_PROC_ERR), cur_cmd};
                    end
                end
                S_OSC: begin
                    wait_count <= wait_count + 23'h000001;
                    if (meter_done) begin
                        state <= S_IDLE;
                        first_word <= osc_ratio;
                        second_word <= {cksum(osc_ratio), `CMD_OSC_RATIO};
                    end else if (wait_count >= NVM_TIMEOUT - 1) begin
                        // a silent link clock must not hang the session
                        state <= S_IDLE;
                        first_word <= `RESP_PROC_ERR;
                        second_word <= {cksum(`RESP_PROC_ERR), `CMD_OSC_RATIO};
                    end
                end
                default: state <= S_NORMAL;
            endcase
        end
    end
endmodule

//--- bench/sensor_far_side_model.sv
`timescale 1ns/1ps
module sensor_far_side_model (
    // clock and reset
    input wire core_clk,
    input wire sys_rst,
    // converter
    input wire conv_run,
    input wire conv_temp_sel,
    output reg conv_done,
    output reg conv_is_temp,
    output reg [15:0] conv_data,
    // nonvolatile memory
    input wire nvm_req,
    input wire fail_mode,
    output reg nvm_done,
    output reg nvm_fail
);
    reg [3:0] tick;
    reg [3:0] nwait;
    // data lines scramble between results so a stale sample never passes
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick <= 4'h0;
            nwait <= 4'h0;
            conv_done <= 1'b0;
            conv_is_temp <= 1'b0;
            conv_data <= 16'h0000;
            nvm_done <= 1'b0;
            nvm_fail <= 1'b0;
        end else begin
            tick <= tick + 4'h1;
            conv_done <= conv_run && tick == 4'hF;
            conv_is_temp <= conv_temp_sel;
            conv_data <= (conv_run && tick == 4'hF) ? (conv_temp_sel ? 16'h1234 : 16'h5678)
                : ~conv_data;
            nwait <= (nvm_req && !nvm_done) ? nwait + 4'h1 : 4'h0;
            nvm_done <= nwait == 4'hB;
            nvm_fail <= (nwait == 4'hB) ? fail_mode : ~nvm_fail;
        end
    end
endmodule

//--- bench/sensor_command_processor_checker.sv
`timescale 1ns/1ps
module sensor_command_processor_checker (
    // watched ports
    input wire core_clk,
    input wire sys_rst,
    input wire cmd_valid,
    input wire [7:0] cmd_byte,
    input wire cmd_end,
    input wire cmd_one_wire,
    input wire cmd_primary,
    input wire conv_run,
    input wire conv_temp_sel,
    input wire conv_done,
    input wire conv_is_temp,
    input wire nvm_req,
    input wire nvm_done,
    input wire nvm_fail,
    input wire [4:0] osc_trim,
    input wire command_session,
    input wire busy,
    input wire secondary_addr_en
);
    reg [7:0] b0;
    reg [7:0] b1;
    wire entry = cmd_end && b0 == 8'h72 && b1 == 8'hD1 && !cmd_one_wire && !busy;
    always @(posedge core_clk) begin
        if (cmd_valid) begin
            b0 <= b1;
            b1 <= cmd_byte;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_trim_reset: assert property ($fell(sys_rst) |-> osc_trim == 5'h12)
        else $error("trim not at reset value");
    a_entry_session: assert property (entry |=> command_session)
        else $error("entry did not open session");
    a_entry_secondary: assert property (entry && cmd_primary |=> secondary_addr_en)
        else $error("secondary address not restored");
    a_entry_halts: assert property ($rose(command_session) |-> !conv_run)
        else $error("conversion still running in session");
    a_nvm_holds: assert property ($rose(nvm_req) |-> nvm_req [*8])
        else $error("nvm request dropped early");
    a_nvm_release: assert property (nvm_req && nvm_done |=> !nvm_req)
        else $error("nvm request held after done");
    a_busy_ignores: assert property (busy && nvm_req && cmd_end |=> $stable(osc_trim))
        else $error("frame taken while busy");
    a_temp_first: assert property (conv_done && conv_is_temp && conv_temp_sel && busy
        && conv_run |=> !conv_temp_sel) else $error("bridge not after temperature");
    c_entry: cover property (entry);
    c_nvm_fail: cover property (nvm_done && nvm_fail);
    c_count_end: cover property ($fell(busy) && !conv_run);
endmodule
bind sensor_command_processor sensor_command_processor_checker i_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_end(cmd_end), .cmd_one_wire(cmd_one_wire), .cmd_primary(cmd_primary),
    .conv_run(conv_run), .conv_temp_sel(conv_temp_sel), .conv_done(conv_done),
    .conv_is_temp(conv_is_temp), .nvm_req(nvm_req), .nvm_done(nvm_done), .nvm_fail(nvm_fail),
    .osc_trim(osc_trim), .command_session(command_session), .busy(busy),
    .secondary_addr_en(secondary_addr_en));

//--- bench/sensor_command_processor_bench.sv
`timescale 1ns/1ps
module sensor_command_processor_bench;
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg one_wire_port = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmd_valid = 1'b0, cmd_end = 1'b0;
    reg one_wire = 1'b0, primary = 1'b1, sfault = 1'b0, fail_mode = 1'b0;
    reg [7:0] paddr = 8'h00, cmd_byte = 8'h00, diag = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire [15:0] cdata;
    wire [4:0] trim;
    wire pready, pslverr, crun, tsel, cdone, ctemp, nreq, ndone, nfail, sess, busy, sec_en;
    integer err_count = 0, check_count = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    // link clock stands still outside one-wire frames
    always #200 one_wire_port = one_wire ? ~one_wire_port : 1'b0;
    sensor_command_processor #(.NVM_TIMEOUT(200)) i_sensor_command_processor (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_end(cmd_end), .cmd_one_wire(one_wire),
        .cmd_primary(primary), .secondary_fault(sfault), .owi_clk_pin(one_wire_port), .conv_run(crun),
        .conv_temp_sel(tsel), .conv_done(cdone), .conv_is_temp(ctemp), .conv_data(cdata),
        .conv_diag(diag), .conv_diag_temporary(1'b0), .charge_pump_en(), .nvm_req(nreq),
        .nvm_op(), .nvm_word(), .nvm_done(ndone), .nvm_fail(nfail), .pump_fault(fail_mode),
        .osc_trim(trim), .command_session(sess), .busy(busy), .secondary_addr_en(sec_en));
    sensor_far_side_model i_sensor_far_side_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .conv_run(crun), .conv_temp_sel(tsel), .conv_done(cdone), .conv_is_temp(ctemp),
        .conv_data(cdata), .nvm_req(nreq), .fail_mode(fail_mode), .nvm_done(ndone),
        .nvm_fail(nfail));
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1) @(posedge core_clk);
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            check(rd, e);
        end
    endtask
    task send(input [23:0] b, input integer n, input wt);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge core_clk);
                cmd_valid <= 1'b1;
                cmd_byte <= b[23 - 8 * i -: 8];
            end
            @(posedge core_clk);
            cmd_valid <= 1'b0;
            cmd_byte <= ~cmd_byte;
            cmd_end <= 1'b1;
            @(posedge core_clk);
            cmd_end <= 1'b0;
            if (wt) begin
                repeat (3) @(posedge core_clk);
                while (busy !== 1'b0) @(posedge core_clk);
            end
        end
    endtask
    task cmd_chk(input [23:0] b, input integer n, input [31:0] w1, input [31:0] w2);
        begin
            send(b, n, 1'b1);
            rchk(8'h00, w1);
            rchk(8'h04, w2);
        end
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(8'h08, 32'h0012);
        rchk(8'h0C, 32'h0800);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, pslverr}, 32'h1);
        $display("test registers done");
        sfault <= 1'b1;
        @(posedge core_clk);
        sfault <= 1'b0;
        send(24'h72D100, 2, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        if (rd !== 32'hC372) send(24'h72D100, 2, 1'b1);
        cmd_chk(24'h72D100, 2, 32'hC372, 32'hCA72);
        check({30'h0, sess, crun}, 32'h2);
        check({31'h0, sec_en}, 32'h1);
        $display("test entry done");
        cmd_chk(24'h990000, 1, 32'hCF00, 32'h3099);
        cmd_chk(24'h620000, 1, 32'hCF00, 32'h3062);
        cmd_chk(24'h650014, 3, 32'h0014, 32'hEB65);
        check({27'h0, trim}, 32'h14);
        cmd_chk(24'h1D0000, 1, 32'h0014, 32'hEB1D);
        cmd_chk(24'h6CF742, 3, 32'hC36C, 32'hD06C);
        rchk(8'h10, 32'h0184);
        cmd_chk(24'hC00000, 1, 32'hC3C0, 32'h7CC0);
        // second frame lands inside the nvm wait and must be dropped
        send(24'hC30000, 1, 1'b0);
        send(24'h650003, 3, 1'b1);
        check({27'h0, trim}, 32'h14);
        rchk(8'h00, 32'hC3C3);
        fail_mode <= 1'b1;
        cmd_chk(24'hC30000, 1, 32'hCFC3, 32'h6DC3);
        cmd_chk(24'hC00000, 1, 32'hC000, 32'h3FC0);
        cmd_chk(24'h6CF742, 3, 32'hCF6C, 32'hC46C);
        fail_mode <= 1'b0;
        send(24'hAD0014, 3, 1'b1);
        send(24'hC90000, 1, 1'b1);
        $display("test commands done");
        apb(1'b1, 8'h0C, 32'h0800);
        cmd_chk(24'h620009, 3, 32'h5678, 32'h1234);
        check({31'h0, crun}, 32'h0);
        one_wire <= 1'b1;
        cmd_chk(24'h500000, 1, 32'h0008, 32'hF750);
        one_wire <= 1'b0;
        diag <= 8'h2A;
        send(24'h010000, 1, 1'b1);
        repeat (20) @(posedge core_clk);
        rchk(8'h00, 32'hC02A);
        check({31'h0, crun}, 32'h0);
        $display("test acquisition done");
        tally_and_finish;
    end
endmodule
